// ===== rtl/ret_consts.vh
`ifndef RET_CONSTS_VH
`define RET_CONSTS_VH

// ---------------------------------------------------------------
// register indices (byte address = index * 4)
// ---------------------------------------------------------------
`define RET_IDX_T1_CFG 6'h0F
`define RET_IDX_T2_CFG 6'h10
`define RET_IDX_T1_PRESET 6'h20
`define RET_IDX_T2_PRESET 6'h21
`define RET_IDX_T1_COUNT 6'h22
`define RET_IDX_T2_COUNT 6'h23
`define RET_IDX_STATUS 6'h24

// ---------------------------------------------------------------
// configuration fields and reset values
// ---------------------------------------------------------------
`define RET_CFG_MASK 32'h001FFFFF
`define RET_CFG_RESET 32'h00000000
`define RET_PRESET_RESET 20'h00000
`define RET_HALT_HI 20
`define RET_HALT_LO 15
`define RET_LAUNCH_HI 14
`define RET_LAUNCH_LO 7
`define RET_BIT_LAUNCH_NOW 6
`define RET_RATE_HI 5
`define RET_RATE_LO 3
`define RET_BIT_CLK_SRC 2
`define RET_BIT_RELOAD 1
`define RET_BIT_ON 0
`define RET_CNT_W 20

// ---------------------------------------------------------------
// timing: core tick of 13.56 MHz built from the 100 MHz system clock
// ---------------------------------------------------------------
`define RET_SYS_CLK_KHZ 17'h186A0
`define RET_CORE_CLK_KHZ 17'h034F8
`define RET_ACC_W 17

`endif

// ===== rtl/ret_timers.v
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
`include "ret_consts.vh"

// Summary of operation
// - first timer halts after four received bits
// - first timer halts when transmission begins
// - first timer halts on external field on/off
// - first timer halts on own field on/off
// - first timer starts on reception begin/end
// - first timer starts on transmission begin/end
// - first timer starts on external field on/off
// - first timer starts on own field on/off
// - immediate-start bit starts first timer at once
// - three-bit selector picks prescaled tick rate
// - clock-source bit picks core or prescaled tick
// - counts down; expiry stops at zero or reloads
// - enable bit gates all first timer operation
// - second timer has same six halt events
// - second timer starts on reception, transmission, field
// - second timer has same low control bits
module ret_timers (
	// system
	input wire clk_i,
	input wire rst_i,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// protocol and field events from the transceiver
	input wire rx_first_bit_i,
	input wire rx_four_bits_i,
	input wire rx_end_i,
	input wire tx_begin_i,
	input wire tx_end_i,
	input wire ext_field_i,
	input wire own_field_i,
	// timer state
	output reg [1:0] timer_expired_o,
	output reg [1:0] timer_running_o
);

	// ---------------------------------------------------------------
	// helper functions
	// ---------------------------------------------------------------

	// byte-lane merge of a bus write into a stored word
	function [31:0] lane_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] sel;
		integer b;
		begin
			lane_merge = old_val;
			for (b = 0; b < 4; b = b + 1) begin
				if (sel[b]) begin
					lane_merge[b*8 +: 8] = new_val[b*8 +: 8];
				end
			end
		end
	endfunction

	// prescaled tick: core rate divided by 2^(sel+1), 6.78 MHz down to 53 kHz
	function rate_tick;
		input [2:0] sel;
		input [7:0] div;
		input core;
		reg [7:0] low_mask;
		begin
			low_mask = 8'hFF >> (3'h7 - sel);
			rate_tick = core && ((div & low_mask) == low_mask);
		end
	endfunction

	// any enabled halt event of a configuration word
	function halt_hit;
		input [31:0] cfg;
		input [20:7] ev;
		begin
			halt_hit = |(cfg[`RET_HALT_HI:`RET_HALT_LO] & ev[`RET_HALT_HI:`RET_HALT_LO]);
		end
	endfunction

	// any enabled launch event of a configuration word
	function launch_hit;
		input [31:0] cfg;
		input [20:7] ev;
		begin
			launch_hit = |(cfg[`RET_LAUNCH_HI:`RET_LAUNCH_LO] & ev[`RET_LAUNCH_HI:`RET_LAUNCH_LO]);
		end
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	reg [31:0] cfg_reg [0:1];
	reg [`RET_CNT_W-1:0] preset_reg [0:1];
	reg [`RET_CNT_W-1:0] cnt_reg [0:1];
	reg [1:0] launch_now_reg;
	reg [`RET_ACC_W-1:0] acc_reg;
	reg core_tick_reg;
	reg [7:0] div_reg;
	reg ext_field_reg;
	reg own_field_reg;
	wire req;
	wire [5:0] idx;
	wire [20:7] ev;
	reg [31:0] rd_data;
	reg [1:0] tick;
	reg [1:0] halt;
	reg [1:0] launch;
	wire [31:0] preset_wr0;
	wire [31:0] preset_wr1;
	integer i;
	// own index for the decision logic, so no variable is shared by two processes
	integer ti;

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign idx = wb_adr_i[7:2];

	// byte-lane merge of preset writes; only the low counter bits are kept
	assign preset_wr0 = lane_merge({12'h000, preset_reg[0]}, wb_dat_i, wb_sel_i);
	assign preset_wr1 = lane_merge({12'h000, preset_reg[1]}, wb_dat_i, wb_sel_i);

	// ---------------------------------------------------------------
	// core tick generation
	// ---------------------------------------------------------------

	// fractional accumulator: 13.56 MHz ticks on average, jitter of one
	// system clock is the price of not needing a second clock domain
	always @(posedge clk_i) begin
		if (rst_i) begin
			acc_reg <= {`RET_ACC_W{1'b0}};
			core_tick_reg <= 1'b0;
			div_reg <= 8'h00;
		end else begin
			if (acc_reg + `RET_CORE_CLK_KHZ >= `RET_SYS_CLK_KHZ) begin
				acc_reg <= acc_reg + `RET_CORE_CLK_KHZ - `RET_SYS_CLK_KHZ;
				core_tick_reg <= 1'b1;
			end else begin
				acc_reg <= acc_reg + `RET_CORE_CLK_KHZ;
				core_tick_reg <= 1'b0;
			end
			if (core_tick_reg) begin
				div_reg <= div_reg + 8'h01; // shared prescaler, free running
			end
		end
	end

	// ---------------------------------------------------------------
	// event detection
	// ---------------------------------------------------------------

	// field levels become edge pulses; other inputs are already pulses
	always @(posedge clk_i) begin
		if (rst_i) begin
			ext_field_reg <= 1'b0;
			own_field_reg <= 1'b0;
		end else begin
			ext_field_reg <= ext_field_i;
			own_field_reg <= own_field_i;
		end
	end

	// event vector laid out like the configuration bits
	assign ev[20] = rx_four_bits_i;
	assign ev[19] = tx_begin_i;
	assign ev[18] = ext_field_i && !ext_field_reg;
	assign ev[17] = !ext_field_i && ext_field_reg;
	assign ev[16] = own_field_i && !own_field_reg;
	assign ev[15] = !own_field_i && own_field_reg;
	assign ev[14] = rx_first_bit_i;
	assign ev[13] = rx_end_i;
	assign ev[12] = tx_begin_i;
	assign ev[11] = tx_end_i;
	assign ev[10] = ext_field_i && !ext_field_reg;
	assign ev[9] = !ext_field_i && ext_field_reg;
	assign ev[8] = own_field_i && !own_field_reg;
	assign ev[7] = !own_field_i && own_field_reg;

	// per-timer tick, halt and launch decisions
	always @* begin
		for (ti = 0; ti < 2; ti = ti + 1) begin
			if (cfg_reg[ti][`RET_BIT_CLK_SRC]) begin
				tick[ti] = rate_tick(cfg_reg[ti][`RET_RATE_HI:`RET_RATE_LO], div_reg,
					core_tick_reg);
			end else begin
				tick[ti] = core_tick_reg;
			end
			halt[ti] = halt_hit(cfg_reg[ti], ev);
			launch[ti] = launch_hit(cfg_reg[ti], ev) || launch_now_reg[ti];
		end
	end

	// ---------------------------------------------------------------
	// timers
	// ---------------------------------------------------------------

	// halt beats launch in the same cycle so a racing stop is not lost
	always @(posedge clk_i) begin
		if (rst_i) begin
			for (i = 0; i < 2; i = i + 1) begin
				cnt_reg[i] <= {`RET_CNT_W{1'b0}};
			end
			timer_running_o <= 2'b00;
			timer_expired_o <= 2'b00;
		end else begin
			for (i = 0; i < 2; i = i + 1) begin
				timer_expired_o[i] <= 1'b0;
				if (!cfg_reg[i][`RET_BIT_ON]) begin
					timer_running_o[i] <= 1'b0;
				end else if (halt[i]) begin
					timer_running_o[i] <= 1'b0;
				end else if (launch[i]) begin
					cnt_reg[i] <= preset_reg[i];
					timer_running_o[i] <= 1'b1;
				end else if (timer_running_o[i] && tick[i]) begin
					if (cnt_reg[i] <= {{(`RET_CNT_W-1){1'b0}}, 1'b1}) begin
						timer_expired_o[i] <= 1'b1;
						if (cfg_reg[i][`RET_BIT_RELOAD]) begin
							cnt_reg[i] <= preset_reg[i];
						end else begin
							cnt_reg[i] <= {`RET_CNT_W{1'b0}};
							timer_running_o[i] <= 1'b0;
						end
					end else begin
						cnt_reg[i] <= cnt_reg[i] - {{(`RET_CNT_W-1){1'b0}}, 1'b1};
					end
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// register file
	// ---------------------------------------------------------------

	// writes take effect on the acknowledged cycle's launch edge
	always @(posedge clk_i) begin
		if (rst_i) begin
			cfg_reg[0] <= `RET_CFG_RESET;
			cfg_reg[1] <= `RET_CFG_RESET;
			preset_reg[0] <= `RET_PRESET_RESET;
			preset_reg[1] <= `RET_PRESET_RESET;
			launch_now_reg <= 2'b00;
		end else begin
			launch_now_reg <= 2'b00;
			if (req && wb_we_i) begin
				if (idx == `RET_IDX_T1_CFG) begin
					cfg_reg[0] <= lane_merge(cfg_reg[0], wb_dat_i, wb_sel_i) & `RET_CFG_MASK;
					launch_now_reg[0] <= wb_sel_i[0] && wb_dat_i[`RET_BIT_LAUNCH_NOW];
				end else if (idx == `RET_IDX_T2_CFG) begin
					cfg_reg[1] <= lane_merge(cfg_reg[1], wb_dat_i, wb_sel_i) & `RET_CFG_MASK;
					launch_now_reg[1] <= wb_sel_i[0] && wb_dat_i[`RET_BIT_LAUNCH_NOW];
				end else if (idx == `RET_IDX_T1_PRESET) begin
					preset_reg[0] <= preset_wr0[`RET_CNT_W-1:0];
				end else if (idx == `RET_IDX_T2_PRESET) begin
					preset_reg[1] <= preset_wr1[`RET_CNT_W-1:0];
				end
			end
		end
	end

	// read decode; unmapped addresses read zero and still acknowledge
	always @* begin
		if (idx == `RET_IDX_T1_CFG) begin
			rd_data = cfg_reg[0];
		end else if (idx == `RET_IDX_T2_CFG) begin
			rd_data = cfg_reg[1];
		end else if (idx == `RET_IDX_T1_PRESET) begin
			rd_data = {12'h000, preset_reg[0]};
		end else if (idx == `RET_IDX_T2_PRESET) begin
			rd_data = {12'h000, preset_reg[1]};
		end else if (idx == `RET_IDX_T1_COUNT) begin
			rd_data = {12'h000, cnt_reg[0]};
		end else if (idx == `RET_IDX_T2_COUNT) begin
			rd_data = {12'h000, cnt_reg[1]};
		end else if (idx == `RET_IDX_STATUS) begin
			rd_data = {30'h00000000, timer_running_o};
		end else begin
			rd_data = 32'h00000000;
		end
	end

	// single-wait-state slave: ack one edge after the request appears
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req;
			if (req && !wb_we_i) begin
				wb_dat_o <= rd_data;
			end
		end
	end

endmodule // ret_timers

// ===== test/ret_timers_monitor.sv
`timescale 1ns/1ps
// ------------------------------
// port checker for the timer pair
// ------------------------------
module ret_timers_monitor (
	// system
	input wire clk_i,
	input wire rst_i,
	// bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// events
	input wire rx_first_bit_i,
	input wire rx_four_bits_i,
	input wire rx_end_i,
	input wire tx_begin_i,
	input wire tx_end_i,
	input wire ext_field_i,
	input wire own_field_i,
	// timers
	input wire [1:0] timer_expired_o,
	input wire [1:0] timer_running_o
);
	reg [20:0] c1_reg;
	reg [20:0] c2_reg;
	wire wr;
	// the block takes a write on the edge that raises ack, not when the master sees it
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o;
	// shadow of both configurations, updated on the edge the block takes them
	always @(posedge clk_i) begin
		if (rst_i) begin
			c1_reg <= 21'h000000;
			c2_reg <= 21'h000000;
		end else if (wr && wb_adr_i[7:2] == 6'h0F) begin
			c1_reg <= {wb_sel_i[2] ? wb_dat_i[20:16] : c1_reg[20:16],
				wb_sel_i[1] ? wb_dat_i[15:8] : c1_reg[15:8],
				wb_sel_i[0] ? wb_dat_i[7:0] : c1_reg[7:0]};
		end else if (wr && wb_adr_i[7:2] == 6'h10) begin
			c2_reg <= {wb_sel_i[2] ? wb_dat_i[20:16] : c2_reg[20:16],
				wb_sel_i[1] ? wb_dat_i[15:8] : c2_reg[15:8],
				wb_sel_i[0] ? wb_dat_i[7:0] : c2_reg[7:0]};
		end
	end
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	chk_halt_rx: assert property (
		c1_reg[0] && c1_reg[20] && rx_four_bits_i |=> !timer_running_o[0])
		else $error("first timer ran on after four bits");
	chk_halt_tx: assert property (
		c1_reg[0] && c1_reg[19] && tx_begin_i |=> !timer_running_o[0])
		else $error("first timer ran on after transmit");
	chk_halt_ext: assert property (
		$rose(ext_field_i) && c1_reg[0] && c1_reg[18] |-> ##[1:3] !timer_running_o[0])
		else $error("first timer ran on after field rise");
	chk_launch_tx: assert property (
		c1_reg[0] && c1_reg[11] && c1_reg[20:15] == 6'h00 && tx_end_i |=> timer_running_o[0])
		else $error("first timer idle after transmit end");
	chk_now_start: assert property (
		wr && wb_sel_i == 4'hF && wb_adr_i[7:2] == 6'h0F && wb_dat_i[6] && wb_dat_i[0]
		&& wb_dat_i[20:15] == 6'h00
		|-> ##2 timer_running_o[0]) else $error("immediate start missed");
	chk_stop_zero: assert property (
		timer_expired_o[0] && c1_reg[0] |-> timer_running_o[0] == c1_reg[1])
		else $error("expiry run state wrong");
	chk_off_idle: assert property (
		!c1_reg[0] |=> !timer_running_o[0] && !timer_expired_o[0])
		else $error("disabled timer active");
	chk_second_halt: assert property (
		c2_reg[0] && c2_reg[19] && tx_begin_i |=> !timer_running_o[1])
		else $error("second timer ran on after transmit");
	chk_second_launch: assert property (
		c2_reg[0] && c2_reg[13] && c2_reg[20:15] == 6'h00 && rx_end_i |=> timer_running_o[1])
		else $error("second timer idle after receive end");
endmodule // ret_timers_monitor

bind ret_timers ret_timers_monitor i_ret_timers_monitor (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .rx_first_bit_i,
	.rx_four_bits_i, .rx_end_i, .tx_begin_i, .tx_end_i, .ext_field_i, .own_field_i,
	.timer_expired_o, .timer_running_o);

// ===== test/ret_timers_bench.sv
`timescale 1ns/1ps
// ------------------------------
// bench for the timer pair
// ------------------------------
module ret_timers_bench;
	logic clk, rst, cyc, stb, we;
	logic [3:0] sel, sm;
	logic [7:0] adr, ca, pa;
	logic [31:0] wd, q, d;
	logic [6:0] ev;
	wire ack;
	wire [31:0] rd;
	wire [1:0] ex, run;
	integer err_total = 0, checks = 0, cyc_n = 0, n, p, k;
	int pm[9] = '{0, 2, 3, 4, 5, 5, 6, 6, 1};
	int hm[6] = '{8, 2, 4, 5, 6, 7};
	real per;
	ret_timers i_ret_timers (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd),
		.wb_ack_o(ack), .rx_first_bit_i(ev[0]), .rx_four_bits_i(ev[1]), .rx_end_i(ev[2]),
		.tx_begin_i(ev[3]), .tx_end_i(ev[4]), .ext_field_i(ev[5]), .own_field_i(ev[6]),
		.timer_expired_o(ex), .timer_running_o(run));
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard; the two rate sweeps together need about 23k cycles
	always @(posedge clk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 90000) begin
			err_total = err_total + 1;
			wrap_up;
		end
	end
	task wrap_up;
		if (err_total == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks = checks + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	// single classic cycle, held until ack is sampled
	task wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= sm;
		adr <= a;
		wd <= v;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// pulses last one cycle, fields move as levels
	task fire(input int i);
		@(posedge clk);
		ev[pm[i]] <= (i != 5 && i != 7);
		@(posedge clk);
		ev[4:0] <= 5'h00;
		repeat (4) @(posedge clk);
	endtask
	// disable first so a stale run cannot fake a start
	task prep(input int i);
		wb(1'b1, ca, 32'h0);
		ev[5] <= (i == 5);
		ev[6] <= (i == 7);
		repeat (4) @(posedge clk);
	endtask
	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		sel = 4'h0;
		sm = 4'hF;
		adr = 8'h00;
		wd = 32'h0;
		ev = 7'h00;
		d = $urandom(32'hC13DA9DF);
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int t = 0; t < 2; t++) begin
			ca = 8'h3C + 8'(4 * t);
			pa = 8'h80 + 8'(4 * t);
			wb(1'b0, ca, 32'h0);
			chk(q, 32'h0);
			d = $urandom;
			wb(1'b1, ca, d);
			wb(1'b0, ca, 32'h0);
			chk(q, d & 32'h001FFFFF);
			// a single-lane write must leave the other bytes alone
			sm = 4'h2;
			k = $urandom;
			wb(1'b1, ca, k);
			sm = 4'hF;
			wb(1'b0, ca, 32'h0);
			chk(q, ((d & 32'hFFFF00FF) | (k & 32'h0000FF00)) & 32'h001FFFFF);
			d = 32'h80000 | ($urandom & 32'h7FFFF);
			wb(1'b1, pa, d);
			wb(1'b0, pa, 32'h0);
			chk(q, d);
			for (k = 0; k < 8; k++) begin
				prep(k);
				wb(1'b1, ca, 32'h1 | (1 << (14 - k)));
				chk(run[t], 1'b0);
				fire(k);
				chk(run[t], 1'b1);
			end
			for (k = 0; k < 6; k++) begin
				prep(hm[k]);
				wb(1'b1, ca, 32'h41 | (1 << (20 - k)));
				repeat (4) @(posedge clk);
				chk(run[t], 1'b1);
				wb(1'b0, 8'h90, 32'h0);
				chk(q[t], 1'b1);
				fire(hm[k]);
				chk(run[t], 1'b0);
			end
			// every prescale code, then s == 8 for the bare core tick
			for (int s = 0; s < 9; s++) begin
				p = 2 + $urandom % 3;
				per = (s == 8) ? 7.375 : 7.375 * (2 ** (s + 1));
				wb(1'b1, pa, p);
				wb(1'b1, ca, 32'h41 | ((s == 8) ? 0 : (4 | (s << 3))));
				n = 0;
				while (ex[t] !== 1'b1) begin
					@(posedge clk);
					n++;
				end
				chk(n >= (p - 1) * per && n <= p * per + 10, 1'b1);
				@(posedge clk);
				chk(run[t], 1'b0);
			end
			// reload keeps running across two expiries
			wb(1'b1, pa, 32'h1);
			wb(1'b1, ca, 32'h43);
			for (k = 0; k < 2; k++) begin
				while (ex[t] !== 1'b1) @(posedge clk);
				@(posedge clk);
				chk(run[t], 1'b1);
			end
			wb(1'b1, ca, 32'h42);
			repeat (3) @(posedge clk);
			chk(run[t], 1'b0);
		end
		// unmapped index reads back zero
		wb(1'b1, 8'hFC, $urandom);
		wb(1'b0, 8'hFC, 32'h0);
		chk(q, 32'h0);
		wrap_up;
	end
endmodule // ret_timers_bench
